// [hw/fte_defines.svh]
// Constants for the table access and block erase sequencer
`ifndef FTE_DEFINES_SVH
`define FTE_DEFINES_SVH

`define FTE_PTR_W 22
`define FTE_ADDR_W 12
`define FTE_BLK_W 4
`define FTE_ERASE_WORDS 6'h20
`define FTE_ERASE_LSB 6
`define FTE_CTRL_PSS 7
`define FTE_CTRL_CSS 6
`define FTE_CTRL_ERA 4
`define FTE_CTRL_ERR 3
`define FTE_CTRL_PERM 2
`define FTE_CTRL_GO 1
`define FTE_UNLOCK_1 8'h55
`define FTE_UNLOCK_2 8'haa
`define FTE_HOLD_RST 8'hff
`define FTE_CFG_READ 8'hff
`define FTE_ERASED_WORD 16'hffff
`define FTE_ERASE_CTRL 8'h94
`define FTE_ERASE_TIME_NS 2000000
`define FTE_CLK_PERIOD_NS 8

`endif

// [hw/fte_device.sv]
// Flash end: table pointer, table latch, holding block, unlock and self-timed erase
`timescale 1ns/1ps
`include "fte_defines.svh"
module fte_device #(
    parameter int ADDR_W = `FTE_ADDR_W,
    parameter int BLK_W = `FTE_BLK_W,
    parameter int ERASE_CYCLES = `FTE_ERASE_TIME_NS / `FTE_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Core side
    fte_if.dev bus,
    // Status
    output logic nvm_busy,
    output logic abort_error_flag
);
    localparam int HOLD_N = 2 ** BLK_W;
    localparam int WORDS = 2 ** (ADDR_W - 1);

    logic [15:0] mem [WORDS];
    logic [7:0] hold_r [HOLD_N];
    logic [21:0] ptr_r;
    logic [21:0] op_ptr_r;
    logic [7:0] latch_r;
    logic pss_r, css_r, era_r, perm_r, go_r, err_r, done_r;
    fte_pkg::fte_dev_state_t state_r, state_nxt;
    fte_pkg::fte_unlock_t unl_r, unl_nxt;
    logic [31:0] timer_r;
    logic [5:0] walk_r;

    // Request decode
    wire accept = bus.cmd_valid && bus.cmd_ready;
    wire busy = state_r != fte_pkg::FTE_DEV_IDLE;
    wire is_rd = accept && bus.cmd == fte_pkg::FTE_CMD_TBL_READ;
    wire is_wr = accept && bus.cmd == fte_pkg::FTE_CMD_TBL_WRITE;
    wire is_ctrl = accept && bus.cmd == fte_pkg::FTE_CMD_SET_CTRL;
    wire is_unl = accept && bus.cmd == fte_pkg::FTE_CMD_SET_UNLOCK;
    wire [7:0] wdat = bus.cmd_data[7:0];

    // Pointer stepping keeps the space bit so a walk never crosses into config space
    wire [21:0] ptr_inc = {ptr_r[21], ptr_r[20:0] + 21'h1};
    wire [21:0] ptr_dec = {ptr_r[21], ptr_r[20:0] - 21'h1};
    wire pre = bus.mode == fte_pkg::FTE_PTR_PRE_INC;
    wire [21:0] acc_ptr = pre ? ptr_inc : ptr_r;
    wire [21:0] ptr_after = (bus.mode == fte_pkg::FTE_PTR_KEEP) ? ptr_r :
        (bus.mode == fte_pkg::FTE_PTR_POST_DEC) ? ptr_dec : ptr_inc;

    // Read path; the config half of the space has no array behind it
    wire [15:0] rd_word = mem[acc_ptr[ADDR_W-1:1]];
    wire [7:0] rd_half = acc_ptr[0] ? rd_word[15:8] : rd_word[7:0];
    wire [7:0] rd_byte = acc_ptr[21] ? `FTE_CFG_READ : rd_half;
    wire [BLK_W-1:0] hold_idx = acc_ptr[BLK_W-1:0];

    // Go request and unlock check
    wire go_req = is_ctrl && wdat[`FTE_CTRL_GO];
    wire unlocked = unl_r == fte_pkg::FTE_UNL_GOT2;
    wire start_ok = go_req && unlocked && wdat[`FTE_CTRL_PERM] && wdat[`FTE_CTRL_PSS] &&
        !wdat[`FTE_CTRL_CSS];
    wire improper = go_req && !start_ok;
    wire timer_end = timer_r == 32'(ERASE_CYCLES - 1);

    always_comb
    begin
        unl_nxt = fte_pkg::FTE_UNL_NONE;
        if (!accept)
        begin
            unl_nxt = unl_r;
        end
        else if (is_unl && wdat == `FTE_UNLOCK_1)
        begin
            unl_nxt = fte_pkg::FTE_UNL_GOT1;
        end
        else if (is_unl && wdat == `FTE_UNLOCK_2 && unl_r == fte_pkg::FTE_UNL_GOT1)
        begin
            unl_nxt = fte_pkg::FTE_UNL_GOT2;
        end
    end

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            fte_pkg::FTE_DEV_IDLE:
            begin
                if (start_ok)
                begin
                    state_nxt = wdat[`FTE_CTRL_ERA] ? fte_pkg::FTE_DEV_ERASE :
                        fte_pkg::FTE_DEV_PROG;
                end
            end
            fte_pkg::FTE_DEV_ERASE, fte_pkg::FTE_DEV_PROG:
            begin
                if (timer_end)
                begin
                    state_nxt = fte_pkg::FTE_DEV_IDLE;
                end
            end
            default:
            begin
                state_nxt = fte_pkg::FTE_DEV_IDLE;
            end
        endcase
    end

    // Array update walks one word per cycle inside the timed window
    wire erasing = state_r == fte_pkg::FTE_DEV_ERASE;
    wire [5:0] walk_lim = erasing ? `FTE_ERASE_WORDS : 6'(HOLD_N / 2);
    wire mem_we = busy && walk_r < walk_lim;
    wire [ADDR_W-2:0] erase_wa = {op_ptr_r[ADDR_W-1:`FTE_ERASE_LSB], walk_r[4:0]};
    wire [ADDR_W-2:0] prog_wa = {op_ptr_r[ADDR_W-1:BLK_W], walk_r[BLK_W-2:0]};
    wire [ADDR_W-2:0] mem_wa = erasing ? erase_wa : prog_wa;
    wire [BLK_W-1:0] hold_lo = {walk_r[BLK_W-2:0], 1'b0};
    wire [BLK_W-1:0] hold_hi = {walk_r[BLK_W-2:0], 1'b1};
    // A holding byte of ff leaves the flash byte as it was
    wire [15:0] prog_wd = mem[prog_wa] & {hold_r[hold_hi], hold_r[hold_lo]};
    wire [15:0] mem_wd = erasing ? `FTE_ERASED_WORD : prog_wd;
    wire prog_end = state_r == fte_pkg::FTE_DEV_PROG && timer_end;

    always_ff @(posedge clk_sys)
    begin
        if (mem_we)
        begin
            mem[mem_wa] <= mem_wd;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < HOLD_N; gi++)
        begin : g_hold
            always_ff @(posedge clk_sys)
            begin
                if (rst || prog_end)
                begin
                    hold_r[gi] <= `FTE_HOLD_RST;
                end
                else if (is_wr && hold_idx == BLK_W'(gi))
                begin
                    hold_r[gi] <= latch_r;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ptr_r <= 22'h0;
            latch_r <= 8'h0;
            op_ptr_r <= 22'h0;
            unl_r <= fte_pkg::FTE_UNL_NONE;
            done_r <= 1'b0;
        end
        else
        begin
            unl_r <= unl_nxt;
            done_r <= accept;
            if (is_rd || is_wr)
            begin
                ptr_r <= ptr_after;
            end
            else if (accept && bus.cmd == fte_pkg::FTE_CMD_SET_PTR)
            begin
                ptr_r <= bus.cmd_data;
            end
            if (is_rd)
            begin
                latch_r <= rd_byte;
            end
            else if (accept && bus.cmd == fte_pkg::FTE_CMD_SET_LATCH)
            begin
                latch_r <= wdat;
            end
            if (start_ok)
            begin
                op_ptr_r <= ptr_r;
            end
        end
    end

    // A reset that cuts a timed operation short is remembered in the error flag
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            err_r <= err_r || busy;
            state_r <= fte_pkg::FTE_DEV_IDLE;
            go_r <= 1'b0;
            {pss_r, css_r, era_r, perm_r} <= 4'h0;
            timer_r <= 32'h0;
            walk_r <= 6'h0;
        end
        else
        begin
            state_r <= state_nxt;
            err_r <= improper || (err_r && !(is_ctrl && !wdat[`FTE_CTRL_ERR]));
            if (is_ctrl)
            begin
                pss_r <= wdat[`FTE_CTRL_PSS];
                css_r <= wdat[`FTE_CTRL_CSS];
                era_r <= wdat[`FTE_CTRL_ERA];
                perm_r <= wdat[`FTE_CTRL_PERM];
            end
            if (start_ok)
            begin
                go_r <= 1'b1;
            end
            else if (busy && timer_end)
            begin
                go_r <= 1'b0;
            end
            timer_r <= busy && !timer_end ? timer_r + 32'h1 : 32'h0;
            walk_r <= !busy ? 6'h0 : (mem_we ? walk_r + 6'h1 : walk_r);
        end
    end

    // Outputs
    assign bus.cmd_ready = !busy;
    assign bus.stall = busy;
    assign bus.done = done_r;
    assign bus.table_latch = latch_r;
    assign bus.table_pointer = ptr_r;
    assign bus.nvm_control_reg = {pss_r, css_r, 1'b0, era_r, err_r, perm_r, go_r, 1'b0};
    assign nvm_busy = busy;
    assign abort_error_flag = err_r;
endmodule

// [hw/fte_host.sv]
// Core end: passes single table commands and runs the guarded erase sequence
`timescale 1ns/1ps
`include "fte_defines.svh"
module fte_host (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Link to the flash end
    fte_if.cpu bus,
    // User request
    input wire logic usr_valid,
    input wire logic usr_erase,
    input wire fte_pkg::fte_cmd_t usr_cmd,
    input wire fte_pkg::fte_ptr_mode_t usr_mode,
    input wire logic [21:0] usr_data,
    output logic usr_ready,
    // User answer
    output logic usr_done,
    output logic [7:0] usr_latch,
    output logic global_irq_enable
);
    fte_pkg::fte_host_state_t st_r;
    fte_pkg::fte_cmd_t cmd_r;
    fte_pkg::fte_ptr_mode_t mode_r;
    logic [21:0] data_r;
    logic erase_r, valid_r, gie_r, done_r;
    logic [2:0] step_r;
    logic [7:0] latch_r;

    // Erase steps: pointer, control, unlock pair, then go
    fte_pkg::fte_cmd_t step_cmd;
    logic [21:0] step_data;
    always_comb
    begin
        step_cmd = fte_pkg::FTE_CMD_SET_CTRL;
        step_data = 22'(`FTE_ERASE_CTRL);
        case (step_r)
            3'h0:
            begin
                step_cmd = fte_pkg::FTE_CMD_SET_PTR;
                step_data = data_r;
            end
            3'h2:
            begin
                step_cmd = fte_pkg::FTE_CMD_SET_UNLOCK;
                step_data = 22'(`FTE_UNLOCK_1);
            end
            3'h3:
            begin
                step_cmd = fte_pkg::FTE_CMD_SET_UNLOCK;
                step_data = 22'(`FTE_UNLOCK_2);
            end
            3'h4:
            begin
                step_data = 22'(`FTE_ERASE_CTRL) | 22'h2;
            end
            default:
            begin
                step_data = 22'(`FTE_ERASE_CTRL);
            end
        endcase
    end

    wire taken = valid_r && bus.cmd_ready;
    wire last_step = !erase_r || step_r == 3'h4;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st_r <= fte_pkg::FTE_H_IDLE;
            cmd_r <= fte_pkg::FTE_CMD_TBL_READ;
            mode_r <= fte_pkg::FTE_PTR_KEEP;
            data_r <= 22'h0;
            erase_r <= 1'b0;
            valid_r <= 1'b0;
            gie_r <= 1'b1;
            done_r <= 1'b0;
            step_r <= 3'h0;
            latch_r <= 8'h0;
        end
        else
        begin
            done_r <= 1'b0;
            case (st_r)
                fte_pkg::FTE_H_IDLE:
                begin
                    if (usr_valid)
                    begin
                        erase_r <= usr_erase;
                        cmd_r <= usr_cmd;
                        mode_r <= usr_mode;
                        data_r <= usr_data;
                        step_r <= 3'h0;
                        gie_r <= !usr_erase;
                        st_r <= fte_pkg::FTE_H_SEND;
                    end
                end
                fte_pkg::FTE_H_SEND:
                begin
                    valid_r <= 1'b1;
                    st_r <= fte_pkg::FTE_H_WAIT;
                end
                fte_pkg::FTE_H_WAIT:
                begin
                    if (taken)
                    begin
                        valid_r <= 1'b0;
                    end
                    if (bus.done)
                    begin
                        latch_r <= bus.table_latch;
                        step_r <= step_r + 3'h1;
                        st_r <= last_step ? (erase_r ? fte_pkg::FTE_H_STALL :
                            fte_pkg::FTE_H_FINISH) : fte_pkg::FTE_H_SEND;
                    end
                end
                fte_pkg::FTE_H_STALL:
                begin
                    if (!bus.stall)
                    begin
                        gie_r <= 1'b1;
                        st_r <= fte_pkg::FTE_H_FINISH;
                    end
                end
                fte_pkg::FTE_H_FINISH:
                begin
                    done_r <= 1'b1;
                    st_r <= fte_pkg::FTE_H_IDLE;
                end
                default:
                begin
                    st_r <= fte_pkg::FTE_H_IDLE;
                end
            endcase
        end
    end

    // Latch value of a table read is sampled on the same edge that sees done high
    assign bus.cmd_valid = valid_r;
    assign bus.cmd = erase_r ? step_cmd : cmd_r;
    assign bus.mode = mode_r;
    assign bus.cmd_data = erase_r ? step_data : data_r;
    assign usr_ready = st_r == fte_pkg::FTE_H_IDLE;
    assign usr_done = done_r;
    assign usr_latch = latch_r;
    assign global_irq_enable = gie_r;
endmodule

// [hw/fte_if.sv]
// Link between the processor core and the flash sequencer
`timescale 1ns/1ps
interface fte_if;
    logic cmd_valid;
    logic cmd_ready;
    fte_pkg::fte_cmd_t cmd;
    fte_pkg::fte_ptr_mode_t mode;
    logic [21:0] cmd_data;
    logic done;
    logic [7:0] table_latch;
    logic [21:0] table_pointer;
    logic [7:0] nvm_control_reg;
    logic stall;
    modport dev (
        input cmd_valid, cmd, mode, cmd_data,
        output cmd_ready, done, table_latch, table_pointer, nvm_control_reg, stall
    );
    modport cpu (
        output cmd_valid, cmd, mode, cmd_data,
        input cmd_ready, done, table_latch, table_pointer, nvm_control_reg, stall
    );
endinterface

// [hw/fte_pkg.sv]
// Types shared by both ends of the sequencer link
package fte_pkg;
    typedef enum logic [2:0] {
        FTE_CMD_TBL_READ,
        FTE_CMD_TBL_WRITE,
        FTE_CMD_SET_PTR,
        FTE_CMD_SET_LATCH,
        FTE_CMD_SET_CTRL,
        FTE_CMD_SET_UNLOCK
    } fte_cmd_t;
    typedef enum logic [1:0] {
        FTE_PTR_KEEP,
        FTE_PTR_POST_INC,
        FTE_PTR_POST_DEC,
        FTE_PTR_PRE_INC
    } fte_ptr_mode_t;
    typedef enum logic [1:0] {FTE_DEV_IDLE, FTE_DEV_ERASE, FTE_DEV_PROG} fte_dev_state_t;
    typedef enum logic [1:0] {FTE_UNL_NONE, FTE_UNL_GOT1, FTE_UNL_GOT2} fte_unlock_t;
    typedef enum logic [2:0] {
        FTE_H_IDLE,
        FTE_H_SEND,
        FTE_H_WAIT,
        FTE_H_STALL,
        FTE_H_FINISH
    } fte_host_state_t;
endpackage

// [testbench/fte_bench.sv]
// Self-checking bench for both ends of the table access and erase link
`timescale 1ns/1ps
module fte_bench;
    localparam int ERASE_CYC = 40;
    localparam fte_pkg::fte_cmd_t RD = fte_pkg::FTE_CMD_TBL_READ;
    localparam fte_pkg::fte_cmd_t PTR = fte_pkg::FTE_CMD_SET_PTR;
    localparam fte_pkg::fte_cmd_t CTL = fte_pkg::FTE_CMD_SET_CTRL;
    localparam fte_pkg::fte_cmd_t UNL = fte_pkg::FTE_CMD_SET_UNLOCK;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic usr_valid = 1'b0;
    logic usr_erase = 1'b0;
    fte_pkg::fte_cmd_t usr_cmd = CTL;
    fte_pkg::fte_ptr_mode_t usr_mode = fte_pkg::FTE_PTR_KEEP;
    logic [21:0] usr_data = 22'h0;
    logic usr_ready;
    logic usr_done;
    logic [7:0] usr_latch;
    logic global_irq_enable;
    logic abort_error_flag;
    logic nvm_busy;
    logic irq_bad = 1'b0;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    int stall_cyc = 0;
    fte_if link();
    fte_device #(.ERASE_CYCLES(ERASE_CYC)) fte_device_inst (.clk_sys(clk_sys), .rst(rst),
        .bus(link), .nvm_busy(nvm_busy), .abort_error_flag(abort_error_flag));
    fte_host fte_host_inst (.clk_sys(clk_sys), .rst(rst), .bus(link), .usr_valid(usr_valid),
        .usr_erase(usr_erase), .usr_cmd(usr_cmd), .usr_mode(usr_mode), .usr_data(usr_data),
        .usr_ready(usr_ready), .usr_done(usr_done), .usr_latch(usr_latch),
        .global_irq_enable(global_irq_enable));
    fte_link_assertions #(.ERASE_CYCLES(ERASE_CYC)) fte_link_assertions_inst (
        .clk_sys(clk_sys), .rst(rst), .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready),
        .cmd(link.cmd), .mode(link.mode), .cmd_data(link.cmd_data), .done(link.done),
        .table_latch(link.table_latch), .table_pointer(link.table_pointer),
        .nvm_control_reg(link.nvm_control_reg), .stall(link.stall));
    always #4 clk_sys = ~clk_sys;
    // Flops update by non-blocking assignment, so old values are sampled here
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (link.stall === 1'b1)
            stall_cyc <= stall_cyc + 1;
        if (link.stall === 1'b1 && usr_erase === 1'b1 && global_irq_enable !== 1'b0)
            irq_bad <= 1'b1;
        if (cycles == 20000)
        begin
            failures++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (failures == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [21:0] seen, input logic [21:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Request is held until the edge that finds the host ready
    task automatic send(input logic er, input fte_pkg::fte_cmd_t c, input logic [21:0] d,
        input fte_pkg::fte_ptr_mode_t m);
        @(posedge clk_sys);
        usr_erase <= er;
        usr_cmd <= c;
        usr_mode <= m;
        usr_data <= d;
        usr_valid <= 1'b1;
        do
            @(negedge clk_sys);
        while (usr_ready !== 1'b1);
        @(posedge clk_sys);
        usr_valid <= 1'b0;
    endtask
    task automatic run(input logic er, input fte_pkg::fte_cmd_t c, input logic [21:0] d,
        input fte_pkg::fte_ptr_mode_t m = fte_pkg::FTE_PTR_KEEP);
        int n;
        send(er, c, d, m);
        n = 0;
        do
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        while (usr_done !== 1'b1 && n < 300);
        check(22'(n < 300), 22'h1);
    endtask
    task automatic t_modes();
        logic [21:0] st [5] = '{22'h200010, 22'h200010, 22'h3fffff, 22'h200000, 22'h3fffff};
        logic [21:0] ex [5] = '{22'h200011, 22'h200010, 22'h200000, 22'h3fffff, 22'h200000};
        fte_pkg::fte_ptr_mode_t md [5] = '{fte_pkg::FTE_PTR_POST_INC, fte_pkg::FTE_PTR_KEEP,
            fte_pkg::FTE_PTR_POST_INC, fte_pkg::FTE_PTR_POST_DEC, fte_pkg::FTE_PTR_PRE_INC};
        for (int i = 0; i < 5; i++)
        begin
            run(1'b0, PTR, st[i]);
            run(1'b0, RD, 22'h0, md[i]);
            check(link.table_pointer, ex[i]);
            check(22'(usr_latch), 22'hff);
        end
    endtask
    // Low pointer bits are nonzero on purpose; the whole block must clear
    task automatic t_erase();
        int s;
        s = stall_cyc;
        run(1'b1, CTL, 22'h000125);
        check(22'(stall_cyc - s), 22'(ERASE_CYC));
        check(22'(irq_bad), 22'h0);
        check(22'(global_irq_enable), 22'h1);
        check(22'(abort_error_flag), 22'h0);
        check(22'(link.nvm_control_reg), 22'h000094);
        run(1'b0, PTR, 22'h000100);
        run(1'b0, RD, 22'h0);
        check(22'(usr_latch), 22'hff);
        run(1'b0, PTR, 22'h00013f);
        run(1'b0, RD, 22'h0);
        check(22'(usr_latch), 22'hff);
    endtask
    // Holding slot is loaded at one address and programmed at another
    task automatic t_prog();
        run(1'b0, PTR, 22'h0007f3);
        run(1'b0, fte_pkg::FTE_CMD_SET_LATCH, 22'h00005a);
        run(1'b0, fte_pkg::FTE_CMD_TBL_WRITE, 22'h0);
        run(1'b0, PTR, 22'h000123);
        run(1'b0, CTL, 22'h000084);
        run(1'b0, UNL, 22'h000055);
        run(1'b0, UNL, 22'h0000aa);
        run(1'b0, CTL, 22'h000086);
        run(1'b0, RD, 22'h0, fte_pkg::FTE_PTR_POST_INC);
        check(22'(usr_latch), 22'h5a);
        run(1'b0, RD, 22'h0);
        check(22'(usr_latch), 22'hff);
    endtask
    task automatic t_bad();
        logic [7:0] sec [3] = '{8'h00, 8'haa, 8'haa};
        logic [7:0] go [3] = '{8'h96, 8'h92, 8'hd6};
        for (int i = 0; i < 3; i++)
        begin
            run(1'b0, CTL, 22'h0);
            run(1'b0, UNL, 22'h000055);
            run(1'b0, UNL, 22'(sec[i]));
            run(1'b0, CTL, 22'(go[i]));
            check(22'(abort_error_flag), 22'h1);
            check(22'(link.stall), 22'h0);
        end
    endtask
    task automatic t_rst();
        int n;
        run(1'b0, CTL, 22'h0);
        send(1'b1, CTL, 22'h000140, fte_pkg::FTE_PTR_KEEP);
        n = 0;
        while (link.stall !== 1'b1 && n < 50)
        begin
            @(posedge clk_sys);
            n++;
        end
        repeat (5) @(posedge clk_sys);
        check(22'(nvm_busy), 22'h1);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        check(22'(abort_error_flag), 22'h1);
        check(22'(link.nvm_control_reg), 22'h000008);
        check(22'(nvm_busy), 22'h0);
        run(1'b0, CTL, 22'h0);
        check(22'(abort_error_flag), 22'h0);
    endtask
    initial
    begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        run(1'b0, CTL, 22'h0);
        check(22'(abort_error_flag), 22'h0);
        t_modes();
        t_erase();
        t_prog();
        t_bad();
        t_rst();
        stop_test();
    end
endmodule

// [testbench/fte_link_assertions.sv]
// Concurrent checks on the link between the core end and the flash end
`timescale 1ns/1ps
`include "fte_defines.svh"
module fte_link_assertions #(
    parameter int ERASE_CYCLES = `FTE_ERASE_TIME_NS / `FTE_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Requests
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire fte_pkg::fte_cmd_t cmd,
    input wire fte_pkg::fte_ptr_mode_t mode,
    input wire logic [21:0] cmd_data,
    // Answers
    input wire logic done,
    input wire logic [7:0] table_latch,
    input wire logic [21:0] table_pointer,
    input wire logic [7:0] nvm_control_reg,
    input wire logic stall
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    logic got1_r;
    logic got2_r;
    logic era_r;
    logic [31:0] cnt_r;
    wire take = cmd_valid && cmd_ready;
    wire tbl = take && (cmd == fte_pkg::FTE_CMD_TBL_READ || cmd == fte_pkg::FTE_CMD_TBL_WRITE);
    wire unl = take && cmd == fte_pkg::FTE_CMD_SET_UNLOCK;
    wire go_take = take && cmd == fte_pkg::FTE_CMD_SET_CTRL && cmd_data[1];
    wire go_ok = go_take && got2_r && cmd_data[7] && cmd_data[2] && !cmd_data[6];
    // Any other taken request breaks the unlock chain
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            got1_r <= 1'b0;
            got2_r <= 1'b0;
        end
        else if (take)
        begin
            got1_r <= unl && cmd_data[7:0] == `FTE_UNLOCK_1;
            got2_r <= unl && cmd_data[7:0] == `FTE_UNLOCK_2 && got1_r;
        end
    end
    // Program cycles may run on another timer, so only erases are timed
    always_ff @(posedge clk_sys)
    begin
        if (go_take)
            era_r <= cmd_data[4];
        if (rst || !stall)
            cnt_r <= 32'h0;
        else
            cnt_r <= cnt_r + 32'h1;
    end
    done_after_take_a: assert property (take |=> done)
        else $error("done missing after a taken request");
    no_stray_done_a: assert property (!take |=> !done)
        else $error("done without a request");
    stall_blocks_ready_a: assert property (stall |-> !cmd_ready)
        else $error("request accepted while stalled");
    ptr_step_up_a: assert property (tbl && mode inside {fte_pkg::FTE_PTR_POST_INC,
        fte_pkg::FTE_PTR_PRE_INC} |=> table_pointer ==
        {$past(table_pointer[21]), $past(table_pointer[20:0]) + 21'h1})
        else $error("pointer increment wrong");
    ptr_step_down_a: assert property (tbl && mode == fte_pkg::FTE_PTR_POST_DEC |=>
        table_pointer == {$past(table_pointer[21]), $past(table_pointer[20:0]) - 21'h1})
        else $error("pointer decrement wrong");
    cfg_read_ff_a: assert property (take && cmd == fte_pkg::FTE_CMD_TBL_READ &&
        table_pointer[21] |=> table_latch == 8'hff)
        else $error("config space read not ff");
    unlock_starts_a: assert property (go_ok |=> stall && nvm_control_reg[1])
        else $error("guarded go did not start");
    no_unguarded_start_a: assert property ($rose(stall) |-> $past(go_ok))
        else $error("timed cycle started without unlock");
    bad_go_error_a: assert property (go_take && !go_ok |=> nvm_control_reg[3])
        else $error("improper go left error clear");
    erase_timer_a: assert property ($fell(stall) && era_r |-> cnt_r == ERASE_CYCLES)
        else $error("erase stall length wrong");
    go_clears_a: assert property ($fell(stall) |-> !nvm_control_reg[1])
        else $error("go bit left set after the cycle");
endmodule
